// >>> verilog/csm_mode_ctrl.sv
/*
 * Sleep and initialization mode-request control of a CAN controller, with
 * its APB register file, resync counter and acceptance-filter storage.
 * Assumes the protocol engine supplies tx_bit, receive status and events,
 * and the processor power state arrives as cpu_stop and cpu_wait levels.
 */
`timescale 1ns/100ps
module csm_mode_ctrl #(
	parameter int ADDR_W = 8,
	parameter int TQ_PER_BIT = csm_pkg::TQ_PER_BIT
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bus_rx_pin,
	output logic bus_tx_pin,
	input wire logic tx_bit,
	input wire logic rx_active,
	input wire logic frame_received,
	input wire logic [2:0] tx_done,
	input wire logic [2:0] tx_aborted,
	input wire logic bus_off,
	input wire logic [1:0] tx_status,
	input wire logic [1:0] rx_status,
	input wire logic cpu_stop,
	input wire logic cpu_wait,
	output logic abort_pulse,
	output logic init_active,
	output logic sleep_active,
	output logic [7:0] mode_ctl1,
	output logic [7:0] bus_timing_0,
	output logic [7:0] bus_timing_1,
	output logic [7:0] acceptance_control,
	output logic [2:0] transmit_abort_request,
	output logic [2:0] transmit_buffer_select
);
	// ==========================================================
	// Bus decode
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a == ADDR_W'(off));
	endfunction

	logic acc, wr;
	logic w_ctl0, w_ctl1, w_btr0, w_btr1, w_rflg, w_rier, w_tflg, w_tier;
	logic w_tarq, w_tbsel, w_idac, in_mem, mapped;
	logic [7:0] wd, rd8;
	logic [7:0] mem_rd;

	assign acc = psel && penable;
	assign wr = acc && pwrite && pstrb[0];
	assign wd = pwdata[7:0];
	assign in_mem = paddr[6] && (paddr[1:0] == 2'b00) && (paddr < ADDR_W'(8'h80));
	assign w_ctl0 = wr && hit(paddr, csm_pkg::OFF_CTL0);
	assign w_ctl1 = wr && hit(paddr, csm_pkg::OFF_CTL1);
	assign w_btr0 = wr && hit(paddr, csm_pkg::OFF_BTR0);
	assign w_btr1 = wr && hit(paddr, csm_pkg::OFF_BTR1);
	assign w_rflg = wr && hit(paddr, csm_pkg::OFF_RFLG);
	assign w_rier = wr && hit(paddr, csm_pkg::OFF_RIER);
	assign w_tflg = wr && hit(paddr, csm_pkg::OFF_TFLG);
	assign w_tier = wr && hit(paddr, csm_pkg::OFF_TIER);
	assign w_tarq = wr && hit(paddr, csm_pkg::OFF_TARQ);
	assign w_tbsel = wr && hit(paddr, csm_pkg::OFF_TBSEL);
	assign w_idac = wr && hit(paddr, csm_pkg::OFF_IDAC);
	assign mapped = in_mem || ((paddr[1:0] == 2'b00) && (paddr <= ADDR_W'(csm_pkg::OFF_IDAC)));
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;

	// ==========================================================
	// Mode state
	logic init_request, init_acknowledge, sleep_request, sleep_acknowledge;
	logic wake_enable, stop_in_wait, timer_en, synch, received_frame_flag;
	logic wake_interrupt_flag, rx_full_flag;
	logic [7:0] receiver_irq_enables;
	logic [2:0] transmit_flags, transmit_irq_enables, transmit_abort_ack;
	logic tx_empty, wake_event, normal_mode, resync_start, resync_done, resync_busy;
	logic [11:0] bit_cycles;
	logic [5:0] ctl1_cfg;

	assign init_active = init_request && init_acknowledge;
	assign sleep_active = sleep_request && sleep_acknowledge;
	assign tx_empty = &transmit_flags;
	// Any dominant level wakes while wake_enable is set; low-pass wake filtering is not modelled
	assign wake_event = sleep_active && wake_enable && !bus_rx_pin;
	assign abort_pulse = init_request && !init_acknowledge;
	assign resync_start = !init_request && init_acknowledge;
	assign normal_mode = !init_active && !sleep_active && synch && !mode_ctl1[csm_pkg::C1_LOOPB];

	// Init request and its acknowledge
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			init_request <= 1'b1;
			init_acknowledge <= 1'b1;
		end else begin
			if (w_ctl0 && wd[csm_pkg::C0_INIT_RQ]) begin
				init_request <= 1'b1;
			end else if (w_ctl0 && init_active) begin
				init_request <= 1'b0;
			end
			if (abort_pulse) begin
				init_acknowledge <= 1'b1;
			end else if (resync_start) begin
				init_acknowledge <= 1'b0;
			end
		end
	end

	// Sleep request and its acknowledge; wake takes priority over a write
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sleep_request <= 1'b0;
			sleep_acknowledge <= 1'b0;
		end else begin
			if (wake_event) begin
				sleep_request <= 1'b0;
			end else if (w_ctl0 && !init_active) begin
				if (wd[csm_pkg::C0_SLEEP_RQ] && !wake_interrupt_flag) begin
					sleep_request <= 1'b1;
				end else if (!wd[csm_pkg::C0_SLEEP_RQ] && sleep_active) begin
					sleep_request <= 1'b0;
				end
			end
			if (!sleep_request || wake_event) begin
				sleep_acknowledge <= 1'b0;
			end else if (!rx_active && tx_empty) begin
				sleep_acknowledge <= 1'b1;
			end
		end
	end

	// Remaining control 0 bits; all but wake_enable held in reset during init
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wake_enable <= 1'b0;
			stop_in_wait <= 1'b0;
			timer_en <= 1'b0;
			received_frame_flag <= 1'b0;
		end else if (init_active) begin
			stop_in_wait <= 1'b0;
			timer_en <= 1'b0;
			received_frame_flag <= 1'b0;
		end else begin
			if (w_ctl0) begin
				wake_enable <= wd[csm_pkg::C0_WAKE_EN];
				stop_in_wait <= wd[csm_pkg::C0_SWAIT];
				timer_en <= wd[csm_pkg::C0_TIME];
			end
			if (frame_received && normal_mode) begin
				received_frame_flag <= 1'b1;
			end else if (w_ctl0 && wd[csm_pkg::C0_FRAME]) begin
				received_frame_flag <= 1'b0;
			end
		end
	end

	// Synchronization drops on init request, returns after resync
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			synch <= 1'b0;
		end else if (init_request) begin
			synch <= 1'b0;
		end else if (resync_done) begin
			synch <= 1'b1;
		end
	end

	assign bit_cycles = 12'((bus_timing_0[5:0] + 12'h001) * 12'(TQ_PER_BIT));

	csm_resync u_resync (
		.clock(clock),
		.rstn(rstn),
		.start(resync_start),
		.bus_off(bus_off),
		.bit_cycles(bit_cycles),
		.bus_rx_pin(bus_rx_pin),
		.busy(resync_busy),
		.done(resync_done)
	);

	// ==========================================================
	// Configuration writable only in init
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctl1_cfg <= csm_pkg::RST_CTL1_CFG;
			bus_timing_0 <= csm_pkg::RST_BYTE;
			bus_timing_1 <= csm_pkg::RST_BYTE;
			acceptance_control <= csm_pkg::RST_BYTE;
		end else if (init_active) begin
			if (w_ctl1) ctl1_cfg <= wd[7:2];
			if (w_btr0) bus_timing_0 <= wd;
			if (w_btr1) bus_timing_1 <= wd;
			if (w_idac) acceptance_control <= wd;
		end
	end
	assign mode_ctl1 = {ctl1_cfg, sleep_acknowledge, init_acknowledge};

	csm_accept_mem #(
		.DEPTH(16),
		.WIDTH(8)
	) u_accept (
		.clock(clock),
		.rstn(rstn),
		.wr_en(wr && in_mem && init_active),
		.wr_idx(paddr[5:2]),
		.wr_data(wd),
		.rd_idx(paddr[5:2]),
		.rd_data(mem_rd)
	);

	// ==========================================================
	// Flag and enable registers reset on init entry
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wake_interrupt_flag <= 1'b0;
			rx_full_flag <= 1'b0;
		end else if (init_active) begin
			wake_interrupt_flag <= 1'b0;
			rx_full_flag <= 1'b0;
		end else begin
			if (wake_event) begin
				wake_interrupt_flag <= 1'b1;
			end else if (w_rflg && wd[csm_pkg::RF_WAKE]) begin
				wake_interrupt_flag <= 1'b0;
			end
			if (frame_received && normal_mode) begin
				rx_full_flag <= 1'b1;
			end else if (w_rflg && wd[csm_pkg::RF_RXF]) begin
				rx_full_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			receiver_irq_enables <= csm_pkg::RST_BYTE;
			transmit_flags <= csm_pkg::RST_TFLG;
			transmit_irq_enables <= csm_pkg::RST_TBUF;
			transmit_abort_request <= csm_pkg::RST_TBUF;
			transmit_abort_ack <= csm_pkg::RST_TBUF;
			transmit_buffer_select <= csm_pkg::RST_TBUF;
		end else if (init_active) begin
			receiver_irq_enables <= csm_pkg::RST_BYTE;
			transmit_flags <= csm_pkg::RST_TFLG;
			transmit_irq_enables <= csm_pkg::RST_TBUF;
			transmit_abort_request <= csm_pkg::RST_TBUF;
			transmit_abort_ack <= csm_pkg::RST_TBUF;
			transmit_buffer_select <= csm_pkg::RST_TBUF;
		end else begin
			if (w_rier) receiver_irq_enables <= wd;
			if (w_tier) transmit_irq_enables <= wd[2:0];
			if (w_tbsel) transmit_buffer_select <= wd[2:0];
			// Completion sets win over a software clear
			transmit_flags <= (transmit_flags & ~(w_tflg ? wd[2:0] : 3'h0)) | tx_done;
			transmit_abort_ack <= (transmit_abort_ack & ~(w_tarq ? ~wd[2:0] : 3'h0))
				| tx_aborted;
			transmit_abort_request <= ((w_tarq ? wd[2:0] : transmit_abort_request)
				& ~transmit_flags) & ~tx_done & ~tx_aborted;
		end
	end

	// ==========================================================
	// Transmit pin: recessive (1) forced so the protocol is never violated
	assign bus_tx_pin = init_request || cpu_stop || (cpu_wait && stop_in_wait)
		|| tx_bit;

	// ==========================================================
	// Read mux; status fields are live and untouched by init
	always_comb begin
		rd8 = 8'h00;
		if (in_mem) begin
			rd8 = mem_rd;
		end else begin
			case (paddr[5:2])
				4'h0: rd8 = {received_frame_flag, rx_active, stop_in_wait, synch,
					timer_en, wake_enable, sleep_request, init_request};
				4'h1: rd8 = mode_ctl1;
				4'h2: rd8 = bus_timing_0;
				4'h3: rd8 = bus_timing_1;
				4'h4: rd8 = {wake_interrupt_flag, 1'b0, rx_status, tx_status, 1'b0,
					rx_full_flag};
				4'h5: rd8 = receiver_irq_enables;
				4'h6: rd8 = {5'h00, transmit_flags};
				4'h7: rd8 = {5'h00, transmit_irq_enables};
				4'h8: rd8 = {5'h00, transmit_abort_request};
				4'h9: rd8 = {5'h00, transmit_abort_ack};
				4'hA: rd8 = {5'h00, transmit_buffer_select};
				4'hB: rd8 = acceptance_control;
				default: rd8 = 8'h00;
			endcase
		end
	end
	assign prdata = (acc && !pwrite && mapped) ? {24'h000000, rd8} : 32'h00000000;

	// ==========================================================
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence s_new_init;
		init_request && !init_acknowledge;
	endsequence
	sequence s_entered;
		init_acknowledge && !synch;
	endsequence

	chk_sleep_idle: assert property ($rose(sleep_acknowledge) |->
		!$past(rx_active) && $past(tx_empty) && $past(sleep_request))
		else $error("sleep acknowledged while bus not idle");
	chk_wake_block: assert property (w_ctl0 && wd[csm_pkg::C0_SLEEP_RQ] &&
		wake_interrupt_flag && !sleep_request |=> !sleep_request)
		else $error("sleep request set while wake flag set");
	chk_wake_exit: assert property (wake_event |=>
		!sleep_request && !sleep_acknowledge && wake_interrupt_flag)
		else $error("bus activity did not end sleep");
	chk_sleep_hold: assert property (w_ctl0 && !wd[csm_pkg::C0_SLEEP_RQ] &&
		sleep_request && !sleep_acknowledge |=> sleep_request)
		else $error("sleep request cleared before sleep entered");
	chk_init_enter: assert property (s_new_init |-> abort_pulse ##1 s_entered)
		else $error("init entry did not abort and acknowledge");
	chk_init_reset: assert property (init_active |=>
		receiver_irq_enables == 8'h00 && transmit_flags == csm_pkg::RST_TFLG && !timer_en)
		else $error("registers not reset in init");
	chk_cfg_lock: assert property (w_btr0 && !init_active |=> $stable(bus_timing_0))
		else $error("timing register written outside init");
	chk_init_hold: assert property (w_ctl0 && !wd[csm_pkg::C0_INIT_RQ] &&
		init_request && !init_acknowledge |=> init_request)
		else $error("init request cleared before init entered");
	chk_tx_force: assert property (init_request || cpu_stop ||
		(cpu_wait && stop_in_wait) |-> bus_tx_pin)
		else $error("transmit pin not recessive when forced");
	chk_frame_normal: assert property ($rose(received_frame_flag) |->
		$past(normal_mode))
		else $error("frame flag set outside normal mode");
	chk_ack_exit: assert property ($fell(init_acknowledge) |->
		!$past(init_request) ##[1:3] resync_busy)
		else $error("init acknowledge cleared with request still set");
endmodule

// >>> verilog/csm_pkg.sv
/*
 * Shared constants for the CAN mode-request control block: register byte
 * offsets, field positions, reset values and bus-resync counts.
 * Assumes an APB slave with 32-bit data and one register per aligned word.
 */
package csm_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFF_CTL0 = 8'h00;
	localparam logic [7:0] OFF_CTL1 = 8'h04;
	localparam logic [7:0] OFF_BTR0 = 8'h08;
	localparam logic [7:0] OFF_BTR1 = 8'h0C;
	localparam logic [7:0] OFF_RFLG = 8'h10;
	localparam logic [7:0] OFF_RIER = 8'h14;
	localparam logic [7:0] OFF_TFLG = 8'h18;
	localparam logic [7:0] OFF_TIER = 8'h1C;
	localparam logic [7:0] OFF_TARQ = 8'h20;
	localparam logic [7:0] OFF_TAK = 8'h24;
	localparam logic [7:0] OFF_TBSEL = 8'h28;
	localparam logic [7:0] OFF_IDAC = 8'h2C;
	// Acceptance code at 0x40..0x5C, mask at 0x60..0x7C
	localparam logic [7:0] OFF_ACC_BASE = 8'h40;
	// ==========================================================
	// Control 0 field positions
	localparam int C0_FRAME = 7;
	localparam int C0_RXACT = 6;
	localparam int C0_SWAIT = 5;
	localparam int C0_SYNCH = 4;
	localparam int C0_TIME = 3;
	localparam int C0_WAKE_EN = 2;
	localparam int C0_SLEEP_RQ = 1;
	localparam int C0_INIT_RQ = 0;
	// Control 1 and receiver flag positions
	localparam int C1_LOOPB = 5;
	localparam int RF_WAKE = 7;
	localparam int RF_RXF = 0;
	// ==========================================================
	// Reset values
	localparam logic [5:0] RST_CTL1_CFG = 6'h00;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_TFLG = 3'h7;
	localparam logic [2:0] RST_TBUF = 3'h0;
	// ==========================================================
	// Resync counts and bit timing
	localparam int RECESSIVE_RUN = 11;
	localparam int BUSOFF_RUNS = 128;
	localparam int TQ_PER_BIT = 10;
endpackage

// >>> verilog/csm_accept_mem.sv
/*
 * Small byte memory holding the acceptance code and mask registers.
 * Assumes one write and one read port on the same clock; read data registered.
 */
`timescale 1ns/100ps
module csm_accept_mem #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 8
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [$clog2(DEPTH)-1:0] rd_idx,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_idx];
		end
	end
endmodule

// >>> verilog/csm_resync.sv
/*
 * Bus resync counter: counts consecutive recessive bits after leaving init.
 * Assumes the receive pin is synchronous to clock; a bit lasts bit_cycles clocks.
 */
`timescale 1ns/100ps
module csm_resync (
	input wire logic clock,
	input wire logic rstn,
	input wire logic start,
	input wire logic bus_off,
	input wire logic [11:0] bit_cycles,
	input wire logic bus_rx_pin,
	output logic busy,
	output logic done
);
	localparam logic [3:0] RUN_LAST = 4'(csm_pkg::RECESSIVE_RUN - 1);
	localparam logic [7:0] RUNS_LAST = 8'(csm_pkg::BUSOFF_RUNS - 1);
	logic [11:0] div;
	logic [3:0] run;
	logic [7:0] runs;
	logic [7:0] runs_last;
	logic tick;

	// ==========================================================
	// Bit-rate enable
	assign tick = busy && (div == 12'h001);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			div <= 12'h001;
		end else if (start || tick) begin
			div <= bit_cycles;
		end else if (busy) begin
			div <= div - 12'h001;
		end
	end

	// ==========================================================
	// Recessive run counting
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			busy <= 1'b0;
			done <= 1'b0;
			run <= 4'h0;
			runs <= 8'h00;
			runs_last <= 8'h00;
		end else begin
			done <= 1'b0;
			if (start) begin
				busy <= 1'b1;
				run <= 4'h0;
				runs <= 8'h00;
				runs_last <= bus_off ? RUNS_LAST : 8'h00;
			end else if (tick) begin
				if (!bus_rx_pin) begin
					run <= 4'h0;
				end else if (run != RUN_LAST) begin
					run <= run + 4'h1;
				end else begin
					run <= 4'h0;
					if (runs == runs_last) begin
						busy <= 1'b0;
						done <= 1'b1;
					end else begin
						runs <= runs + 8'h01;
					end
				end
			end
		end
	end

	chk_done_count: assert property (@(posedge clock) disable iff (!rstn)
		done |-> $past(run) == RUN_LAST && $past(runs) == $past(runs_last))
		else $error("resync finished before the recessive run count");
endmodule

// >>> sim/csm_bus_model.sv
/*
 * Far side of the block: transceiver and CAN bus seen as one wired-AND line.
 * Assumes the bench asks for remote traffic through drive_dominant.
 */
`timescale 1ns/100ps
module csm_bus_model (
	input wire logic bus_tx_pin,
	input wire logic drive_dominant,
	output logic bus_rx_pin
);
	// ==========================================
	// Bus level
	// Any node pulling dominant wins; idle bus floats recessive
	assign bus_rx_pin = bus_tx_pin & ~drive_dominant;
endmodule

// >>> sim/tb_top.sv
/*
 * Self-checking bench for the CAN mode-request block over APB.
 * Assumes an APB slave that may insert wait states, and the bus model for the far side.
 */
`timescale 1ns/100ps
module tb_top;
	// ==========================================
	// Signals
	logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic tx_bit = 1, rx_active = 0, frame_received = 0, bus_off = 0;
	logic cpu_stop = 0, cpu_wait = 0, dom = 0;
	logic bus_rx_pin, bus_tx_pin, pready, pslverr, abort_pulse, last_err;
	logic init_active, sleep_active;
	logic [7:0] paddr = 0, rd_n, mode_ctl1, bus_timing_0, bus_timing_1, acceptance_control;
	logic [2:0] tx_done = 0, transmit_abort_request, transmit_buffer_select;
	logic [31:0] pwdata = 0, prdata;
	logic [3:0] pstrb = 0;
	logic [1:0] tx_status = 0, rx_status = 0;
	int miscompares = 0, comparisons = 0;
	always #25 clock = ~clock;
	csm_bus_model bus (.bus_tx_pin(bus_tx_pin), .drive_dominant(dom), .bus_rx_pin(bus_rx_pin));
	csm_mode_ctrl dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin),
		.tx_bit(tx_bit), .rx_active(rx_active), .frame_received(frame_received),
		.tx_done(tx_done), .tx_aborted(3'h0), .bus_off(bus_off), .tx_status(tx_status),
		.rx_status(rx_status), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait),
		.abort_pulse(abort_pulse), .init_active(init_active), .sleep_active(sleep_active),
		.mode_ctl1(mode_ctl1), .bus_timing_0(bus_timing_0), .bus_timing_1(bus_timing_1),
		.acceptance_control(acceptance_control),
		.transmit_abort_request(transmit_abort_request),
		.transmit_buffer_select(transmit_buffer_select));
	// ==========================================
	// Tasks
	task automatic finish_test();
		$display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		pstrb <= 4'hF;
		@(posedge clock);
		penable <= 1'b1;
		// Only the slave or the watchdog ends a wait
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		r = prdata[7:0];
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		acc(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] r;
		acc(1'b0, a, 8'h00, r);
		chk(r & m, e);
	endtask
	task automatic pin(input logic e);
		@(negedge clock);
		chk({7'h00, bus_tx_pin}, {7'h00, e});
	endtask
	task automatic frame();
		@(posedge clock);
		frame_received <= 1'b1;
		@(posedge clock);
		frame_received <= 1'b0;
	endtask
	// ==========================================
	// Tests
	initial begin
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		rd(csm_pkg::OFF_CTL0, 8'hFF, 8'h01);
		rd(csm_pkg::OFF_CTL1, 8'hFF, 8'h01);
		rd(csm_pkg::OFF_TFLG, 8'hFF, 8'h07);
		pin(1'b1);
		wr(csm_pkg::OFF_BTR0, 8'h41);
		rd(csm_pkg::OFF_BTR0, 8'hFF, 8'h41);
		wr(csm_pkg::OFF_BTR1, 8'h12);
		wr(csm_pkg::OFF_IDAC, 8'h33);
		wr(csm_pkg::OFF_CTL1, 8'h20);
		wr(8'h64, 8'h5A);
		rd(8'h64, 8'hFF, 8'h5A);
		rd(csm_pkg::OFF_CTL1, 8'hFF, 8'h21);
		wr(csm_pkg::OFF_CTL1, 8'h00);
		@(negedge clock);
		chk(mode_ctl1, 8'h01);
		chk(bus_timing_0, 8'h41);
		chk(bus_timing_1, 8'h12);
		chk(acceptance_control, 8'h33);
		chk({7'h00, init_active}, 8'h01);
		frame();
		rd(csm_pkg::OFF_CTL0, 8'h80, 8'h00);
		acc(1'b0, 8'h30, 8'h00, rd_n);
		chk({7'h00, last_err}, 8'h01);
		// Leave init; bit time is 20 clocks, so 220 clocks to resync
		wr(csm_pkg::OFF_CTL0, 8'h00);
		rd(csm_pkg::OFF_CTL1, 8'h01, 8'h00);
		wr(csm_pkg::OFF_BTR0, 8'h00);
		rd(csm_pkg::OFF_BTR0, 8'hFF, 8'h41);
		wr(8'h64, 8'hA5);
		rd(8'h64, 8'hFF, 8'h5A);
		wr(csm_pkg::OFF_CTL1, 8'h20);
		rd(csm_pkg::OFF_CTL1, 8'h20, 8'h00);
		repeat (178) @(posedge clock);
		rd(csm_pkg::OFF_CTL0, 8'h10, 8'h00);
		repeat (60) @(posedge clock);
		rd(csm_pkg::OFF_CTL0, 8'h10, 8'h10);
		frame();
		rd(csm_pkg::OFF_CTL0, 8'h80, 8'h80);
		wr(csm_pkg::OFF_CTL0, 8'h80);
		// Sleep held off by reception and by a full buffer; early clear ignored
		rx_active <= 1'b1;
		wr(csm_pkg::OFF_TFLG, 8'h01);
		wr(csm_pkg::OFF_CTL0, 8'h02);
		wr(csm_pkg::OFF_CTL0, 8'h00);
		rd(csm_pkg::OFF_CTL0, 8'h02, 8'h02);
		rd(csm_pkg::OFF_CTL1, 8'h02, 8'h00);
		rx_active <= 1'b0;
		rd(csm_pkg::OFF_CTL1, 8'h02, 8'h00);
		@(posedge clock);
		tx_done <= 3'h1;
		@(posedge clock);
		tx_done <= 3'h0;
		rd(csm_pkg::OFF_TFLG, 8'hFF, 8'h07);
		rd(csm_pkg::OFF_CTL1, 8'h02, 8'h02);
		@(negedge clock);
		chk({7'h00, sleep_active}, 8'h01);
		wr(csm_pkg::OFF_CTL0, 8'h00);
		rd(csm_pkg::OFF_CTL1, 8'h02, 8'h00);
		// Wake by bus activity
		wr(csm_pkg::OFF_RIER, 8'h80);
		wr(csm_pkg::OFF_CTL0, 8'h06);
		rd(csm_pkg::OFF_CTL1, 8'h02, 8'h02);
		dom <= 1'b1;
		repeat (2) @(posedge clock);
		dom <= 1'b0;
		rd(csm_pkg::OFF_CTL0, 8'h06, 8'h04);
		rd(csm_pkg::OFF_RFLG, 8'h80, 8'h80);
		wr(csm_pkg::OFF_CTL0, 8'h06);
		rd(csm_pkg::OFF_CTL0, 8'h02, 8'h00);
		wr(csm_pkg::OFF_RFLG, 8'h80);
		// Forced recessive in stop and in wait
		tx_bit <= 1'b0;
		pin(1'b0);
		@(posedge clock);
		cpu_stop <= 1'b1;
		pin(1'b1);
		@(posedge clock);
		cpu_stop <= 1'b0;
		wr(csm_pkg::OFF_CTL0, 8'h20);
		cpu_wait <= 1'b1;
		pin(1'b1);
		wr(csm_pkg::OFF_CTL0, 8'h0C);
		pin(1'b0);
		@(posedge clock);
		cpu_wait <= 1'b0;
		// Init entry resets state but keeps live status
		tx_status <= 2'h2;
		rx_status <= 2'h1;
		wr(csm_pkg::OFF_RIER, 8'hFF);
		wr(csm_pkg::OFF_TIER, 8'h07);
		wr(csm_pkg::OFF_TFLG, 8'h02);
		wr(csm_pkg::OFF_TARQ, 8'h02);
		wr(csm_pkg::OFF_TBSEL, 8'h05);
		@(negedge clock);
		chk({5'h00, transmit_abort_request}, 8'h02);
		chk({5'h00, transmit_buffer_select}, 8'h05);
		frame();
		wr(csm_pkg::OFF_CTL0, 8'h0D);
		pin(1'b1);
		chk({7'h00, abort_pulse}, 8'h01);
		rd(csm_pkg::OFF_CTL1, 8'h01, 8'h01);
		rd(csm_pkg::OFF_CTL0, 8'hFF, 8'h05);
		rd(csm_pkg::OFF_RIER, 8'hFF, 8'h00);
		rd(csm_pkg::OFF_TIER, 8'hFF, 8'h00);
		rd(csm_pkg::OFF_RFLG, 8'hFF, 8'h18);
		rd(csm_pkg::OFF_TFLG, 8'hFF, 8'h07);
		rd(csm_pkg::OFF_TARQ, 8'hFF, 8'h00);
		rd(csm_pkg::OFF_TBSEL, 8'hFF, 8'h00);
		// Loopback kept on so the frame flag must stay clear after resync
		wr(csm_pkg::OFF_CTL1, 8'h20);
		// Bus-off: 128 runs of 11 bits at 20 clocks
		bus_off <= 1'b1;
		tx_bit <= 1'b1;
		wr(csm_pkg::OFF_CTL0, 8'h00);
		repeat (27900) @(posedge clock);
		rd(csm_pkg::OFF_CTL0, 8'h10, 8'h00);
		repeat (500) @(posedge clock);
		rd(csm_pkg::OFF_CTL0, 8'h10, 8'h10);
		frame();
		rd(csm_pkg::OFF_CTL0, 8'h80, 8'h00);
		finish_test();
	end
	initial begin
		#1700000;
		miscompares++;
		finish_test();
	end
endmodule
